/* verilog/esa_pkg.sv */
package esa_pkg;

  localparam int          ADDR_W      = 15;
  localparam int          MEM_DEPTH   = 32768;
  localparam logic [3:0]  DEV_ID      = 4'ha;
  localparam logic [3:0]  CNT_ACK     = 4'h8;
  localparam logic [3:0]  CNT_END     = 4'h9;
  localparam logic [3:0]  SIZE_LG_MIN = 4'h7;
  localparam logic [3:0]  SIZE_LG_MAX = 4'hf;
  localparam logic [14:0] PTR_RST     = 15'h0000;
  localparam logic [7:0]  BYTE_RST    = 8'h00;

  typedef struct packed {
    logic scl;
    logic sda;
  } esa_pins_s;

  localparam esa_pins_s PINS_IDLE = '{scl: 1'b1, sda: 1'b1};

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_CTRL    = 6'h02,
    ST_ADDR_HI = 6'h04,
    ST_ADDR_LO = 6'h08,
    ST_WDATA   = 6'h10,
    ST_RDATA   = 6'h20
  } esa_state_e;

endpackage

/* verilog/esa_slave.sv */
`timescale 1ns/10ps
module esa_slave (
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  // static configuration
  input  wire logic       two_byte_mode,
  input  wire logic [3:0] size_log2,
  input  wire logic [2:0] chip_sel,
  // bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe
);

  esa_pkg::esa_pins_s  s1_q, s2_q, s3_q, flt_q;
  esa_pkg::esa_pins_s  s1_d, s2_d, s3_d, flt_d;
  esa_pkg::esa_state_e st_q, st_d;
  logic [3:0]          cnt_q, cnt_d;
  logic [7:0]          shift_q, shift_d;
  logic [7:0]          tx_q, tx_d;
  logic [7:0]          hi_q, hi_d;
  logic [2:0]          blk_q, blk_d;
  logic [14:0]         ptr_q, ptr_d;
  logic                mack_q, mack_d;
  logic                oe_q, oe_d;
  logic                sda_o_q;
  logic                scl_rise, scl_fall, start, stop;
  logic                mem_we;
  logic [14:0]         mem_wa;
  logic [7:0]          mem_wd;
  logic [7:0]          rd_byte;
  logic [7:0]          mem_q [0:esa_pkg::MEM_DEPTH-1];

  // size mask from a clamped log2 size
  function automatic logic [14:0] wrap_addr(input logic [14:0] a, input logic [3:0] lg);
    logic [3:0]  l;
    logic [15:0] m;
    l = (lg < esa_pkg::SIZE_LG_MIN) ? esa_pkg::SIZE_LG_MIN :
        (lg > esa_pkg::SIZE_LG_MAX) ? esa_pkg::SIZE_LG_MAX : lg;
    m = (16'h0001 << l) - 16'h0001;
    return a & m[14:0];
  endfunction

  assign rd_byte = mem_q[ptr_q];
  assign sda_oe  = oe_q;
  assign sda_o   = sda_o_q;

  always_comb begin
    s1_d     = s1_q;
    s2_d     = s2_q;
    s3_d     = s3_q;
    flt_d    = flt_q;
    st_d     = st_q;
    cnt_d    = cnt_q;
    shift_d  = shift_q;
    tx_d     = tx_q;
    hi_d     = hi_q;
    blk_d    = blk_q;
    ptr_d    = ptr_q;
    mack_d   = mack_q;
    oe_d     = oe_q;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start    = 1'b0;
    stop     = 1'b0;
    mem_we   = 1'b0;
    mem_wa   = ptr_q;
    mem_wd   = shift_q;
    if (ce) begin
      s1_d      = '{scl: scl_i, sda: sda_i};
      s2_d      = s1_q;
      s3_d      = s2_q;
      flt_d.scl = (s2_q.scl == s3_q.scl) ? s3_q.scl : flt_q.scl;
      flt_d.sda = (s2_q.sda == s3_q.sda) ? s3_q.sda : flt_q.sda;
      scl_rise  = !flt_q.scl && flt_d.scl;
      scl_fall  = flt_q.scl && !flt_d.scl;
      start     = flt_q.scl && flt_d.scl && flt_q.sda && !flt_d.sda;
      stop      = flt_q.scl && flt_d.scl && !flt_q.sda && flt_d.sda;
      if (start) begin
        st_d  = esa_pkg::ST_CTRL;
        cnt_d = 4'h0;
        oe_d  = 1'b0;
      end else if (stop) begin
        // a half-sent address leaves the pointer as it was
        st_d  = esa_pkg::ST_IDLE;
        cnt_d = 4'h0;
        oe_d  = 1'b0;
      end else if (scl_rise) begin
        if (cnt_q < esa_pkg::CNT_ACK) begin
          shift_d = {shift_q[6:0], flt_d.sda};
        end else if (cnt_q == esa_pkg::CNT_ACK) begin
          mack_d = !flt_d.sda;
        end
        if (cnt_q != esa_pkg::CNT_END) begin
          cnt_d = cnt_q + 4'h1;
        end
      end else if (scl_fall) begin
        if (st_q == esa_pkg::ST_RDATA) begin
          if (cnt_q == esa_pkg::CNT_END) begin
            cnt_d = 4'h0;
            if (mack_q) begin
              tx_d  = rd_byte;
              oe_d  = !rd_byte[7];
              ptr_d = wrap_addr(ptr_q + 15'h0001, size_log2);
            end else begin
              st_d = esa_pkg::ST_IDLE;
              oe_d = 1'b0;
            end
          end else if (cnt_q == esa_pkg::CNT_ACK) begin
            oe_d = 1'b0;
          end else begin
            tx_d = {tx_q[6:0], 1'b0};
            oe_d = !tx_q[6];
          end
        end else if (cnt_q == esa_pkg::CNT_END) begin
          cnt_d = 4'h0;
          oe_d  = 1'b0;
        end else if (cnt_q == esa_pkg::CNT_ACK) begin
          case (st_q)
            esa_pkg::ST_CTRL: begin
              if (shift_q[7:4] == esa_pkg::DEV_ID &&
                  (!two_byte_mode || shift_q[3:1] == chip_sel)) begin
                oe_d  = 1'b1;
                blk_d = shift_q[3:1];
                if (shift_q[0]) begin
                  st_d = esa_pkg::ST_RDATA;
                  if (!two_byte_mode) begin
                    ptr_d = wrap_addr({4'h0, shift_q[3:1], ptr_q[7:0]}, size_log2);
                  end
                end else begin
                  st_d = two_byte_mode ? esa_pkg::ST_ADDR_HI : esa_pkg::ST_ADDR_LO;
                end
              end else begin
                st_d = esa_pkg::ST_IDLE;
              end
            end
            esa_pkg::ST_ADDR_HI: begin
              hi_d = shift_q;
              oe_d = 1'b1;
              st_d = esa_pkg::ST_ADDR_LO;
            end
            esa_pkg::ST_ADDR_LO: begin
              oe_d = 1'b1;
              st_d = esa_pkg::ST_WDATA;
              if (two_byte_mode) begin
                ptr_d = wrap_addr({hi_q[6:0], shift_q}, size_log2);
              end else begin
                ptr_d = wrap_addr({4'h0, blk_q, shift_q}, size_log2);
              end
            end
            esa_pkg::ST_WDATA: begin
              oe_d   = 1'b1;
              mem_we = 1'b1;
              ptr_d  = wrap_addr(ptr_q + 15'h0001, size_log2);
            end
            default: begin
              oe_d = 1'b0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q    <= esa_pkg::PINS_IDLE;
      s2_q    <= esa_pkg::PINS_IDLE;
      s3_q    <= esa_pkg::PINS_IDLE;
      flt_q   <= esa_pkg::PINS_IDLE;
      st_q    <= esa_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
      shift_q <= esa_pkg::BYTE_RST;
      tx_q    <= esa_pkg::BYTE_RST;
      hi_q    <= esa_pkg::BYTE_RST;
      blk_q   <= 3'h0;
      ptr_q   <= esa_pkg::PTR_RST;
      mack_q  <= 1'b0;
      oe_q    <= 1'b0;
      sda_o_q <= 1'b0;
    end else begin
      s1_q    <= s1_d;
      s2_q    <= s2_d;
      s3_q    <= s3_d;
      flt_q   <= flt_d;
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      tx_q    <= tx_d;
      hi_q    <= hi_d;
      blk_q   <= blk_d;
      ptr_q   <= ptr_d;
      mack_q  <= mack_d;
      oe_q    <= oe_d;
      sda_o_q <= 1'b0;
    end
  end

  // storage has no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  byte_ack_a: assert property (
    (scl_fall && cnt_q == esa_pkg::CNT_ACK &&
     (st_q == esa_pkg::ST_ADDR_HI || st_q == esa_pkg::ST_ADDR_LO || st_q == esa_pkg::ST_WDATA))
    |=> sda_oe && (st_q != esa_pkg::ST_IDLE))
    else $error("received byte not acknowledged");

  read_drive_a: assert property (
    (scl_fall && st_q == esa_pkg::ST_RDATA && cnt_q == esa_pkg::CNT_END && mack_q)
    |=> (tx_q == $past(rd_byte)) && (sda_oe == !tx_q[7]) && (cnt_q == 4'h0))
    else $error("read byte not driven from memory");

  single_addr_a: assert property (
    (scl_fall && cnt_q == esa_pkg::CNT_ACK && st_q == esa_pkg::ST_ADDR_LO && !two_byte_mode)
    |=> ptr_q == wrap_addr({4'h0, $past(blk_q), $past(shift_q)}, size_log2)
        && st_q == esa_pkg::ST_WDATA)
    else $error("single byte address wrong");

  two_addr_a: assert property (
    (scl_fall && cnt_q == esa_pkg::CNT_ACK && st_q == esa_pkg::ST_ADDR_LO && two_byte_mode)
    |=> ptr_q == wrap_addr({$past(hi_q[6:0]), $past(shift_q)}, size_log2))
    else $error("two byte address wrong");

  partial_keep_a: assert property (
    (stop && st_q == esa_pkg::ST_ADDR_LO) |=> $stable(ptr_q) && st_q == esa_pkg::ST_IDLE)
    else $error("partial address moved the pointer");

  write_store_a: assert property (
    mem_we |=> mem_q[$past(mem_wa)] == $past(mem_wd) && ptr_q != $past(ptr_q))
    else $error("written byte not stored");

  wrap_range_a: assert property (
    $stable(size_log2) [*2] |-> ptr_q == wrap_addr(ptr_q, size_log2))
    else $error("pointer outside memory size");

  write_seen_c: cover property (mem_we ##[1:1000] mem_we);
  read_nack_c:  cover property (st_q == esa_pkg::ST_RDATA ##1 st_q == esa_pkg::ST_IDLE);
  reject_c:     cover property (st_q == esa_pkg::ST_CTRL ##1 st_q == esa_pkg::ST_IDLE);

endmodule

/* testbench/esa_mst_model.sv */
`timescale 1ns/10ps
module esa_mst_model (
  // clock and resolved wire
  input  wire logic clk,
  input  wire logic sda_w,
  // master drive, sda_oe pulls the wire low
  output logic      scl,
  output logic      sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // p low: start or repeated start, p high: stop
  task cond(input logic p);
    tk(5);
    sda_oe = p;
    tk(5);
    scl = 1'b1;
    tk(8);
    sda_oe = !p;
    tk(8);
    scl = p;
  endtask
  // eight bits msb first, then the ack slot; a one releases the wire
  task xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      tk(5);
      sda_oe = !d[i];
      tk(5);
      scl = 1'b1;
      tk(5);
      q[i] = sda_w;
      tk(5);
      scl = 1'b0;
    end
  endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic       clk = 1'b0, arst_n = 1'b0, two_byte_mode = 1'b0, ce = 1'b1;
  logic [3:0] size_log2 = 4'h7;
  logic [2:0] chip_sel = 3'h0;
  logic       scl, m_oe, s_oe, s_out, sda_w;
  logic [8:0] q9;
  int         errors = 0, checks = 0;
  always #5 clk = ~clk;
  // open drain: the device only pulls low when it drives a zero
  assign sda_w = !(m_oe || (s_oe && !s_out));
  esa_slave u_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .two_byte_mode(two_byte_mode),
    .size_log2(size_log2), .chip_sel(chip_sel), .scl_i(scl), .sda_i(sda_w), .sda_o(s_out),
    .sda_oe(s_oe));
  esa_mst_model u_mst (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_oe(m_oe));
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task tx(input logic [7:0] d, input logic nack);
    u_mst.xfer({d, 1'b1}, q9);
    chk("ack", 16'(nack), 16'(q9[0]));
  endtask
  // straps change only while reset is held
  task boot(input logic two, input logic [3:0] lg, input logic [2:0] sel);
    arst_n = 1'b0;
    two_byte_mode = two;
    size_log2 = lg;
    chip_sel = sel;
    u_mst.tk(4);
    arst_n = 1'b1;
  endtask
  function logic [7:0] ctl(input logic two, input logic [15:0] a, input logic r);
    return {esa_pkg::DEV_ID, two ? chip_sel : a[10:8], r};
  endfunction
  task setp(input logic two, input logic [15:0] a);
    u_mst.cond(1'b0);
    tx(ctl(two, a, 1'b0), 1'b0);
    if (two) tx(a[15:8], 1'b0);
    tx(a[7:0], 1'b0);
  endtask
  task wr(input logic two, input logic [15:0] a, input logic [7:0] d);
    setp(two, a);
    tx(d, 1'b0);
    u_mst.cond(1'b1);
    u_mst.cond(1'b0);
    tx(ctl(two, a, 1'b0), 1'b0);
    u_mst.cond(1'b1);
  endtask
  task rd(input logic two, input logic [15:0] a, output logic [7:0] d);
    setp(two, a);
    u_mst.cond(1'b0);
    tx(ctl(two, a, 1'b1), 1'b0);
    u_mst.xfer(9'h1ff, q9);
    d = q9[8:1];
    chk("sda out", 16'h0000, 16'(s_out));
    u_mst.cond(1'b1);
    chk("sda idle", 16'h0001, 16'(sda_w));
  endtask
  // clock enable low freezes the bus logic, then chip select is compared
  task t_strap();
    boot(1'b1, 4'hc, 3'h5);
    ce = 1'b0;
    u_mst.cond(1'b0);
    tx({esa_pkg::DEV_ID, 3'h5, 1'b0}, 1'b1);
    u_mst.cond(1'b1);
    ce = 1'b1;
    u_mst.cond(1'b0);
    tx({esa_pkg::DEV_ID, 3'h0, 1'b0}, 1'b1);
    u_mst.cond(1'b0);
    tx({esa_pkg::DEV_ID, 3'h5, 1'b0}, 1'b0);
    u_mst.cond(1'b1);
    $display("test done, clock enable and chip select");
  endtask
  // scheme detection, a wrong device id byte and a block 7 control byte (refused in two-byte mode only), then the doubling size search
  task t_run(input logic two, input logic [3:0] lg);
    logic [7:0]  t, v;
    logic [16:0] n;
    logic [4:0]  code;
    boot(two, lg, 3'h0);
    wr(1'b1, 16'h0001, 8'h01);
    wr(1'b1, 16'h0000, 8'h01);
    rd(1'b0, 16'h0000, t);
    chk("scheme", 16'(two), 16'(t));
    u_mst.cond(1'b0);
    tx(8'hb0, 1'b1);
    u_mst.cond(1'b0);
    tx({esa_pkg::DEV_ID, 3'h7, 1'b0}, two);
    n = two ? 17'h0_1000 : 17'h0_0080;
    code = 5'h01;
    for (logic [16:0] k = n; k < (17'h0_0001 << lg); k = k << 1) wr(two, k[15:0], 8'h55);
    while (n <= (two ? 17'h0_8000 : 17'h0_0800)) begin
      rd(two, 16'h0000, t);
      rd(two, n[15:0], v);
      if (v === t) begin
        wr(two, 16'h0000, t + 8'h01);
        rd(two, n[15:0], v);
        if (v === t + 8'h01) begin
          wr(two, 16'h0000, t);
          rd(two, 16'h0000, v);
          chk("restore", 16'(t), 16'(v));
          break;
        end
      end
      n = n << 1;
      code = code << 1;
    end
    chk("size", 16'h0001 << lg, n[15:0]);
    if (!two) chk("model code", 16'h0001 << (lg - 4'h7), 16'(code));
    $display("test done, two_byte_mode %0d size_log2 %0d", two, lg);
  endtask
  initial begin
    t_strap();
    t_run(1'b0, 4'h7);
    t_run(1'b0, 4'hb);
    t_run(1'b1, 4'hc);
    t_run(1'b1, 4'hf);
    complete_run();
  end
  initial begin
    #900_000 errors = errors + 1;
    complete_run();
  end
endmodule
